// ### include/fpes_pkg.sv
package fpes_pkg;
    // ****************************************************************
    // Bus and array geometry
    // ****************************************************************
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          SECTOR_W        = 12;
    localparam int          SECTOR_CNT      = 8;
    localparam logic [15:0] FLASH_BASE      = 16'h8000;

    // ****************************************************************
    // Command sequence addresses and data
    // ****************************************************************
    localparam logic [15:0] CMD_ADDR_A      = 16'h4555;
    localparam logic [15:0] CMD_ADDR_B      = 16'h4aaa;
    localparam logic [15:0] CTRL_ADDR       = 16'h0fff;
    localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_SECTOR_ERS  = 8'h30;
    localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;

    // ****************************************************************
    // Mode field of flash_control_reg
    // ****************************************************************
    localparam int          MODE_LSB        = 4;
    localparam logic [3:0]  MODE_UNLOCK     = 4'h3;
    localparam logic [3:0]  MODE_LOCK       = 4'hc;
    localparam logic [3:0]  MODE_RESET      = 4'hc;
    localparam logic [7:0]  CTRL_LOW_BITS   = 8'h08;

    // ****************************************************************
    // Operation timing at 10 MHz (100 ns)
    // ****************************************************************
    localparam int          CLK_NS          = 100;
    localparam int          PROG_TIME_NS    = 4000;
    localparam int          ERASE_TIME_NS   = 40000;
    localparam logic [15:0] PROG_CYC        = 16'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] ERASE_CYC       = 16'((ERASE_TIME_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] SECTOR_BYTES    = 16'h1000;

    // ****************************************************************
    // Sequencer states, Gray along erase write path
    // ****************************************************************
    typedef enum logic [2:0] {
        FPES_IDLE  = 3'b000,
        FPES_UNL1  = 3'b001,
        FPES_UNL2  = 3'b011,
        FPES_ESET  = 3'b010,
        FPES_EUNL1 = 3'b110,
        FPES_EUNL2 = 3'b111,
        FPES_PROG  = 3'b101
    } fpes_state_t;

    typedef enum logic [1:0] {
        FPES_OP_NONE  = 2'b00,
        FPES_OP_PROG  = 2'b01,
        FPES_OP_ERASE = 2'b11
    } fpes_op_t;
endpackage : fpes_pkg

// ### include/fpes_bus_if.sv
`timescale 1ns/100ps
interface fpes_bus_if;
    import fpes_pkg::*;
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              busy;

    modport device (input wr, rd, addr, wdata, output rdata, rvalid, busy);
    modport host   (output wr, rd, addr, wdata, input rdata, rvalid, busy);
endinterface : fpes_bus_if

// ### hdl/fpes_device.sv
`timescale 1ns/100ps
// Functional notes
// - Mode field 0011B unlocks command sequences
// - Mode field 1100B locks command sequences
// - Six-write sequence erases one sector
// - Four-write sequence programs one byte
// - Erase busy: paired reads differ
// - Program busy: paired reads differ
// - Host clears interrupt enable before commands
// - Host keeps non-maskable interrupts off (host drives only IRQ_EN; no NMI control)
// - Busy flash reads return status only
module fpes_device
    import fpes_pkg::*;
(
    // Clock and reset
    input  wire logic  CLK,
    input  wire logic  NRST,
    // CPU bus
    fpes_bus_if.device BUS,
    // Status
    output logic       BUSY,
    output logic [3:0] MODE
);
    // ****************************************************************
    // Storage and state
    // ****************************************************************
    // Array is not reset: contents are unknown until erased
    logic [DATA_W-1:0] mem_r [0:SECTOR_CNT*(1<<SECTOR_W)-1];
    logic [3:0]        mode_r;
    fpes_state_t       state_r;
    fpes_state_t       state_nxt;
    fpes_op_t          op_r;
    logic [15:0]       cnt_r;
    logic [14:0]       tgt_r;
    logic [DATA_W-1:0] pdata_r;
    logic              toggle_r;
    logic [DATA_W-1:0] rdata_r;
    logic              rvalid_r;
    logic              busy_r;
    logic [11:0]       clr_r;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire        in_flash  = BUS.addr[15];
    wire [14:0] off       = BUS.addr[14:0];
    wire        ctrl_hit  = BUS.addr == CTRL_ADDR;
    wire        ctrl_wr   = BUS.wr && ctrl_hit;
    // Only the exact unlock code opens the sequencer
    wire        unlocked  = (mode_r == MODE_UNLOCK);
    // Writes during an operation are dropped, not queued
    wire        cmd_wr    = BUS.wr && unlocked && !busy_r && (op_r == FPES_OP_NONE);
    wire        hit_a     = BUS.addr == CMD_ADDR_A;
    wire        hit_b     = BUS.addr == CMD_ADDR_B;
    wire        d_u1      = BUS.wdata == CMD_UNLOCK1;
    wire        d_u2      = BUS.wdata == CMD_UNLOCK2;
    wire        d_prog    = BUS.wdata == CMD_PROGRAM;
    wire        d_eset    = BUS.wdata == CMD_ERASE_SETUP;
    wire        start_prg = cmd_wr && (state_r == FPES_PROG) && in_flash;
    wire        start_ers = cmd_wr && (state_r == FPES_EUNL2) && in_flash
                            && (BUS.wdata == CMD_SECTOR_ERS);
    wire        erase_done = (op_r == FPES_OP_ERASE) && (clr_r == 12'hfff);
    wire        prog_done  = (op_r == FPES_OP_PROG) && (cnt_r == 16'h0001);
    // Erase delay over: one byte of the sector is cleared per cycle
    wire        clr_phase  = (op_r == FPES_OP_ERASE) && (cnt_r <= 16'h0001);
    wire        counting   = cnt_r > 16'h0001;
    wire [14:0] clr_addr   = {tgt_r[14:SECTOR_W], clr_r};
    // Status byte: bit 6 toggles on every flash read while busy
    wire [DATA_W-1:0] status = {1'b0, toggle_r, 6'h00};
    // Read selection; a busy flash read never reaches the array
    wire        rd_status  = BUS.rd && in_flash && busy_r;
    wire        rd_array   = BUS.rd && in_flash && !busy_r;
    wire        rd_ctrl    = BUS.rd && ctrl_hit;
    // Control readback: mode plus fixed low bits
    wire [DATA_W-1:0] ctrl_val = {mode_r, CTRL_LOW_BITS[3:0]};

    // ****************************************************************
    // Command decoder
    // ****************************************************************
    // Any unexpected write drops back to idle; no partial restart
    always_comb begin
        state_nxt = state_r;
        if (cmd_wr) begin
            unique case (state_r)
                FPES_IDLE:  state_nxt = (hit_a && d_u1) ? FPES_UNL1 : FPES_IDLE;
                FPES_UNL1:  state_nxt = (hit_b && d_u2) ? FPES_UNL2 : FPES_IDLE;
                FPES_UNL2: begin
                    if (hit_a && d_prog) begin
                        state_nxt = FPES_PROG;
                    end else if (hit_a && d_eset) begin
                        state_nxt = FPES_ESET;
                    end else begin
                        state_nxt = FPES_IDLE;
                    end
                end
                FPES_ESET:  state_nxt = (hit_a && d_u1) ? FPES_EUNL1 : FPES_IDLE;
                FPES_EUNL1: state_nxt = (hit_b && d_u2) ? FPES_EUNL2 : FPES_IDLE;
                FPES_EUNL2: state_nxt = FPES_IDLE;
                FPES_PROG:  state_nxt = FPES_IDLE;
                default:    state_nxt = FPES_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Control register and sequencer
    // ****************************************************************
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_r  <= MODE_RESET;
            state_r <= FPES_IDLE;
        end else begin
            if (ctrl_wr) begin
                mode_r <= BUS.wdata[MODE_LSB+3:MODE_LSB];
            end
            // Locking mid-sequence also abandons the sequence
            state_r <= unlocked ? state_nxt : FPES_IDLE;
        end
    end

    // ****************************************************************
    // Operation timer
    // ****************************************************************
    // Erase clears one byte per cycle after its delay
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            op_r    <= FPES_OP_NONE;
            cnt_r   <= 16'h0000;
            tgt_r   <= 15'h0000;
            pdata_r <= 8'h00;
            busy_r  <= 1'b0;
            clr_r   <= 12'h000;
        end else if (start_prg) begin
            op_r    <= FPES_OP_PROG;
            cnt_r   <= PROG_CYC;
            tgt_r   <= off;
            pdata_r <= BUS.wdata;
            busy_r  <= 1'b1;
        end else if (start_ers) begin
            op_r    <= FPES_OP_ERASE;
            cnt_r   <= ERASE_CYC;
            // Erase target rounded down to its sector start
            tgt_r   <= {off[14:SECTOR_W], 12'h000};
            busy_r  <= 1'b1;
            clr_r   <= 12'h000;
        end else if (prog_done || erase_done) begin
            op_r    <= FPES_OP_NONE;
            cnt_r   <= 16'h0000;
            busy_r  <= 1'b0;
        end else if (counting) begin
            cnt_r   <= cnt_r - 16'h0001;
        end else if (clr_phase) begin
            clr_r   <= clr_r + 12'h001;
        end
    end

    // ****************************************************************
    // Flash array
    // ****************************************************************
    // Array update kept apart: no reset on the memory itself
    always_ff @(posedge CLK) begin
        if (prog_done) begin
            mem_r[tgt_r] <= mem_r[tgt_r] & pdata_r;
        end else if (clr_phase) begin
            mem_r[clr_addr] <= 8'hff;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Valid answers every read strobe one cycle later
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rvalid_r <= 1'b0;
            toggle_r <= 1'b0;
        end else begin
            rvalid_r <= BUS.rd;
            if (rd_status) begin
                toggle_r <= ~toggle_r;
            end
        end
    end

    // Data holds until the next read; unmapped reads return zero
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_r <= 8'h00;
        end else if (rd_status) begin
            rdata_r <= status;
        end else if (rd_array) begin
            rdata_r <= mem_r[off];
        end else if (rd_ctrl) begin
            rdata_r <= ctrl_val;
        end else if (BUS.rd) begin
            rdata_r <= 8'h00;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign BUS.rdata  = rdata_r;
    assign BUS.rvalid = rvalid_r;
    assign BUS.busy   = busy_r;
    assign BUSY       = busy_r;
    assign MODE       = mode_r;
endmodule : fpes_device

// ### hdl/fpes_host.sv
`timescale 1ns/100ps
module fpes_host
    import fpes_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Device bus
    fpes_bus_if.host         BUS,
    // User request
    input  wire logic        REQ_ERASE,
    input  wire logic        REQ_PROG,
    input  wire logic [15:0] REQ_ADDR,
    input  wire logic [7:0]  REQ_DATA,
    output logic             IRQ_EN,
    output logic             DONE,
    output logic             IDLE
);
    // Gray codes along request, commands, poll and lock
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_UNLK = 3'b001,
        H_CMD  = 3'b011,
        H_RD1  = 3'b010,
        H_W1   = 3'b110,
        H_W2   = 3'b111,
        H_LOCK = 3'b101
    } fpes_hstate_t;

    fpes_hstate_t      st_r;
    logic [2:0]        idx_r;
    logic              ers_r;
    logic [15:0]       tgt_r;
    logic [7:0]        dat_r;
    logic [7:0]        first_r;
    logic              wr_r;
    logic              rd_r;
    logic [15:0]       addr_r;
    logic [7:0]        wdata_r;
    logic              ien_r;
    logic              done_r;
    logic              idle_r;
    logic [2:0]        last_idx;
    logic [15:0]       seq_addr;
    logic [7:0]        seq_data;

    // Command table: index walks the fixed write sequence
    assign last_idx = ers_r ? 3'd5 : 3'd3;
    always_comb begin
        seq_addr = CMD_ADDR_A;
        seq_data = CMD_UNLOCK1;
        unique case (idx_r)
            3'd1: begin
                seq_addr = CMD_ADDR_B;
                seq_data = CMD_UNLOCK2;
            end
            3'd2: begin
                seq_data = ers_r ? CMD_ERASE_SETUP : CMD_PROGRAM;
            end
            3'd3: begin
                if (!ers_r) begin
                    seq_addr = tgt_r;
                    seq_data = dat_r;
                end
            end
            3'd4: begin
                seq_addr = CMD_ADDR_B;
                seq_data = CMD_UNLOCK2;
            end
            3'd5: begin
                seq_addr = tgt_r;
                seq_data = CMD_SECTOR_ERS;
            end
            default: ;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_r    <= H_IDLE;
            idx_r   <= 3'd0;
            ers_r   <= 1'b0;
            tgt_r   <= 16'h0000;
            dat_r   <= 8'h00;
            first_r <= 8'h00;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            addr_r  <= 16'h0000;
            wdata_r <= 8'h00;
            ien_r   <= 1'b1;
            done_r  <= 1'b0;
            idle_r  <= 1'b1;
        end else begin
            wr_r   <= 1'b0;
            rd_r   <= 1'b0;
            done_r <= 1'b0;
            unique case (st_r)
                H_IDLE: begin
                    if (REQ_ERASE || REQ_PROG) begin
                        ers_r   <= REQ_ERASE;
                        tgt_r   <= REQ_ADDR;
                        dat_r   <= REQ_DATA;
                        ien_r   <= 1'b0;
                        wr_r    <= 1'b1;
                        addr_r  <= CTRL_ADDR;
                        wdata_r <= {MODE_UNLOCK, CTRL_LOW_BITS[3:0]};
                        idx_r   <= 3'd0;
                        idle_r  <= 1'b0;
                        st_r    <= H_UNLK;
                    end
                end
                H_UNLK, H_CMD: begin
                    wr_r    <= 1'b1;
                    addr_r  <= seq_addr;
                    wdata_r <= seq_data;
                    idx_r   <= idx_r + 3'd1;
                    st_r    <= (idx_r == last_idx) ? H_RD1 : H_CMD;
                end
                // Poll the target itself: only flash addresses report status
                H_RD1: begin
                    rd_r   <= 1'b1;
                    addr_r <= tgt_r;
                    st_r   <= H_W1;
                end
                H_W1: begin
                    if (BUS.rvalid) begin
                        first_r <= BUS.rdata;
                        rd_r    <= 1'b1;
                        st_r    <= H_W2;
                    end
                end
                H_W2: begin
                    if (BUS.rvalid) begin
                        st_r <= (BUS.rdata == first_r) ? H_LOCK : H_RD1;
                    end
                end
                H_LOCK: begin
                    wr_r    <= 1'b1;
                    addr_r  <= CTRL_ADDR;
                    wdata_r <= {MODE_LOCK, CTRL_LOW_BITS[3:0]};
                    ien_r   <= 1'b1;
                    done_r  <= 1'b1;
                    idle_r  <= 1'b1;
                    st_r    <= H_IDLE;
                end
                default: begin
                    idle_r <= 1'b1;
                    st_r   <= H_IDLE;
                end
            endcase
        end
    end

    assign BUS.wr    = wr_r;
    assign BUS.rd    = rd_r;
    assign BUS.addr  = addr_r;
    assign BUS.wdata = wdata_r;
    assign IRQ_EN    = ien_r;
    assign DONE      = done_r;
    assign IDLE      = idle_r;
endmodule : fpes_host

// ### test/fpes_properties.sv
`timescale 1ns/100ps
// ********
// Link checker
// ********
module fpes_properties
    import fpes_pkg::*;
(
    // Clock and reset
    input wire logic              CLK,
    input wire logic              NRST,
    // Link signals
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              rvalid,
    input wire logic              busy
);
    localparam logic [23:0] W_U1 = {CMD_ADDR_A, CMD_UNLOCK1};
    localparam logic [23:0] W_U2 = {CMD_ADDR_B, CMD_UNLOCK2};
    localparam logic [23:0] W_ES = {CMD_ADDR_A, CMD_ERASE_SETUP};
    localparam logic [23:0] W_PG = {CMD_ADDR_A, CMD_PROGRAM};

    logic [3:0]  mode_r;
    logic [23:0] h_r [4];
    logic        st_r;
    logic        st_v_r;

    // History of writes, so a start of busy can be traced to its sequence
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_r <= MODE_RESET;
            h_r    <= '{default: '0};
            st_r   <= 1'b0;
            st_v_r <= 1'b0;
        end else begin
            if (wr && addr == CTRL_ADDR)
                mode_r <= wdata[7:4];
            if (wr)
                h_r <= '{{addr, wdata}, h_r[0], h_r[1], h_r[2]};
            if (rvalid && busy) begin
                st_r   <= rdata[6];
                st_v_r <= 1'b1;
            end else if (!busy)
                st_v_r <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    property p_start_unlocked;
        $rose(busy) |-> mode_r == MODE_UNLOCK && h_r[0][23];
    endproperty
    a_start_unlocked: assert property (p_start_unlocked) else $error("busy without unlock");
    property p_host_unlock;
        wr && {addr, wdata} == W_U1 |-> mode_r == MODE_UNLOCK;
    endproperty
    a_host_unlock: assert property (p_host_unlock) else $error("sequence while locked");
    property p_erase_seq;
        $rose(busy) && h_r[1] != W_PG |->
            h_r[0][7:0] == CMD_SECTOR_ERS && h_r[1] == W_U2 && h_r[2] == W_U1 && h_r[3] == W_ES;
    endproperty
    a_erase_seq: assert property (p_erase_seq) else $error("erase order wrong");
    property p_prog_seq;
        $rose(busy) && h_r[1] == W_PG |-> h_r[2] == W_U2 && h_r[3] == W_U1;
    endproperty
    a_prog_seq: assert property (p_prog_seq) else $error("program order wrong");
    property p_status_bits;
        rvalid && busy && $past(busy) |-> (rdata & 8'hbf) == 8'h00;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits wrong");
    property p_status_toggle;
        rvalid && busy && st_v_r |-> rdata[6] != st_r;
    endproperty
    a_status_toggle: assert property (p_status_toggle) else $error("status reads equal");
    property p_lock_idle;
        wr && addr == CTRL_ADDR && wdata[7:4] == MODE_LOCK |-> !busy;
    endproperty
    a_lock_idle: assert property (p_lock_idle) else $error("lock while busy");
    property p_poll_after;
        $fell(busy) |-> ##[0:30] rd;
    endproperty
    a_poll_after: assert property (p_poll_after) else $error("no poll after busy");
    property p_read_answer;
        rd |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    c_erase: cover property ($rose(busy) && h_r[0][7:0] == CMD_SECTOR_ERS);
    c_prog: cover property ($rose(busy) && h_r[1] == W_PG);
    c_lock: cover property (wr && addr == CTRL_ADDR && wdata[7:4] == MODE_LOCK);
endmodule : fpes_properties

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
    import fpes_pkg::*;
    localparam int DLY = 5;
    logic        CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        req_erase = 1'b0;
    logic        req_prog = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0]  req_data = 8'h00;
    logic        irq_en, done, idle, busy1, busy2, dif;
    logic [3:0]  mode1, mode2;
    logic [7:0]  v, f;
    int          err_total = 0;
    int          n_checks = 0;

    fpes_bus_if bus();
    fpes_bus_if bus2();
    always #50 CLK = ~CLK;

    fpes_host i_fpes_host(.CLK(CLK), .NRST(NRST), .BUS(bus), .REQ_ERASE(req_erase),
        .REQ_PROG(req_prog), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .IRQ_EN(irq_en),
        .DONE(done), .IDLE(idle));
    fpes_device i_fpes_device(.CLK(CLK), .NRST(NRST), .BUS(bus), .BUSY(busy1), .MODE(mode1));
    // Second device is driven by the bench so that faulty sequences can be tried
    fpes_device i_fpes_device2(.CLK(CLK), .NRST(NRST), .BUS(bus2), .BUSY(busy2), .MODE(mode2));
    fpes_properties i_fpes_properties(.CLK(CLK), .NRST(NRST), .wr(bus.wr), .rd(bus.rd),
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid),
        .busy(bus.busy));

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        #DLY;
        bus2.wr = 1'b1;
        bus2.addr = a;
        bus2.wdata = d;
        @(posedge CLK);
        #DLY;
        bus2.wr = 1'b0;
    endtask : wr8

    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        int n;
        @(posedge CLK);
        #DLY;
        bus2.rd = 1'b1;
        bus2.addr = a;
        @(posedge CLK);
        #DLY;
        bus2.rd = 1'b0;
        for (n = 0; n < 4 && bus2.rvalid !== 1'b1; n++) begin
            @(posedge CLK);
            #DLY;
        end
        if (bus2.rvalid !== 1'b1) begin
            err_total++;
            final_report();
        end
        d = bus2.rdata;
    endtask : rd8

    // Reads in pairs until two agree; reports first read and whether the first pair differed
    task automatic poll(input logic [15:0] a, output logic [7:0] fr, output logic [7:0] d,
                        output logic df);
        logic [7:0] x, y;
        int         n;
        rd8(a, x);
        fr = x;
        rd8(a, y);
        df = (x !== y);
        for (n = 0; n < 2000 && x !== y; n++) begin
            rd8(a, x);
            rd8(a, y);
        end
        if (x !== y) begin
            err_total++;
            final_report();
        end
        d = y;
    endtask : poll

    task automatic prog2(input logic [15:0] a, input logic [7:0] d);
        wr8(CMD_ADDR_A, CMD_UNLOCK1);
        wr8(CMD_ADDR_B, CMD_UNLOCK2);
        wr8(CMD_ADDR_A, CMD_PROGRAM);
        wr8(a, d);
    endtask : prog2

    task automatic erase2(input logic [15:0] a);
        wr8(CMD_ADDR_A, CMD_UNLOCK1);
        wr8(CMD_ADDR_B, CMD_UNLOCK2);
        wr8(CMD_ADDR_A, CMD_ERASE_SETUP);
        wr8(CMD_ADDR_A, CMD_UNLOCK1);
        wr8(CMD_ADDR_B, CMD_UNLOCK2);
        wr8(a, CMD_SECTOR_ERS);
    endtask : erase2

    task automatic host_op(input logic er, input logic [15:0] a, input logic [7:0] d);
        int   n;
        logic seen;
        seen = 1'b0;
        @(posedge CLK);
        #DLY;
        req_erase = er;
        req_prog = !er;
        req_addr = a;
        req_data = d;
        @(posedge CLK);
        #DLY;
        req_erase = 1'b0;
        req_prog = 1'b0;
        for (n = 0; n < 8000 && done !== 1'b1; n++) begin
            @(posedge CLK);
            #DLY;
            if (busy1 === 1'b1 && !seen) begin
                seen = 1'b1;
                chk({7'h0, irq_en}, 8'h00);
                chk({4'h0, mode1}, {4'h0, MODE_UNLOCK});
            end
        end
        if (done !== 1'b1) begin
            err_total++;
            final_report();
        end
        // The lock write lands one edge after the done pulse
        @(posedge CLK);
        #DLY;
        chk({3'h0, seen, mode1}, {4'h1, MODE_LOCK});
        for (n = 0; n < 8 && (idle !== 1'b1 || irq_en !== 1'b1); n++) begin
            @(posedge CLK);
            #DLY;
        end
        chk({6'h0, idle, irq_en}, 8'h03);
    endtask : host_op

    initial begin
        bus2.wr = 1'b0;
        bus2.rd = 1'b0;
        bus2.addr = 16'h0000;
        bus2.wdata = 8'h00;
        repeat (12) @(posedge CLK);
        #DLY;
        NRST = 1'b1;
        chk({mode1, 2'h0, irq_en, busy1}, {MODE_RESET, 4'h2});
        host_op(1'b1, 16'he123, 8'h00);
        chk(i_fpes_device.mem_r[15'h6fff], 8'hff);
        host_op(1'b0, 16'he000, 8'h3f);
        chk(i_fpes_device.mem_r[15'h6000], 8'h3f);
        // Locked device must ignore a full sequence
        prog2(16'he000, 8'h00);
        rd8(CTRL_ADDR, v);
        chk({v[7:4], 3'h0, busy2}, {MODE_LOCK, 4'h0});
        wr8(CTRL_ADDR, {MODE_UNLOCK, CTRL_LOW_BITS[3:0]});
        rd8(CTRL_ADDR, v);
        chk(v, {MODE_UNLOCK, CTRL_LOW_BITS[3:0]});
        erase2(16'he123);
        poll(16'he123, f, v, dif);
        chk({7'h0, dif}, 8'h01);
        chk(f & 8'hbf, 8'h00);
        rd8(16'he000, v);
        chk(v, 8'hff);
        rd8(16'hefff, v);
        chk(v, 8'hff);
        prog2(16'he000, 8'h3f);
        poll(16'he000, f, v, dif);
        chk({7'h0, dif}, 8'h01);
        chk(v, 8'h3f);
        chk(f & 8'hbf, 8'h00);
        // Broken third write returns the decoder to idle
        wr8(CMD_ADDR_A, CMD_UNLOCK1);
        wr8(CMD_ADDR_B, CMD_UNLOCK2);
        wr8(CMD_ADDR_A, 8'h11);
        wr8(16'he001, 8'h00);
        rd8(16'he001, v);
        chk({v[7:1], busy2}, 8'hfe);
        wr8(CTRL_ADDR, {MODE_LOCK, CTRL_LOW_BITS[3:0]});
        rd8(CTRL_ADDR, v);
        chk(v, {MODE_LOCK, CTRL_LOW_BITS[3:0]});
        prog2(16'he003, 8'h00);
        erase2(16'he000);
        rd8(16'he003, v);
        chk(v, 8'hff);
        rd8(16'he000, v);
        chk(v, 8'h3f);
        final_report();
    end
endmodule : tb
